// ===== rtl/nvsc_host.sv
`timescale 1ns/1ps
module nvsc_host #(
  parameter int STORE_CYC  = nvsc_pkg::SOFT_STORE_CYC,
  parameter int RECALL_CYC = nvsc_pkg::SOFT_RECALL_CYC,
  parameter int PWRUP_CYC  = nvsc_pkg::PU_RECALL_CYC
) (
  // Clock and reset
  input  wire logic                        MCLK_IN,
  input  wire logic                        ARST_N_IN,
  // User request port
  input  wire logic                        REQ_VALID_IN,
  input  wire nvsc_pkg::nvsc_req_t         REQ_IN,
  output logic                             REQ_READY_OUT,
  // User answer port
  output logic                             RSP_VALID_OUT,
  output logic [nvsc_pkg::DATA_W-1:0]      RSP_RDATA_OUT,
  output logic                             STORE_INHIBIT_OUT,
  // Supply sense, high while supply is above threshold
  input  wire logic                        PWR_OK_IN,
  // Memory pins
  output nvsc_pkg::nvsc_pins_t             MEM_PINS_OUT,
  input  wire logic [nvsc_pkg::DATA_W-1:0] MEM_DQ_IN
);
  import nvsc_pkg::*;

  localparam int TW = 24;

  initial begin
    if (STORE_CYC < 1 || STORE_CYC >= (1 << TW)) $error("STORE_CYC out of range");
    if (RECALL_CYC < 1 || RECALL_CYC >= (1 << TW)) $error("RECALL_CYC out of range");
    if (PWRUP_CYC < 1 || PWRUP_CYC >= (1 << TW)) $error("PWRUP_CYC out of range");
  end

  typedef enum logic [2:0] {
    S_BOOT,    // Waiting for supply and power-up recall
    S_IDLE,    // Ready for a request
    S_SETUP,   // Address settles with strobes high
    S_STROBE,  // Chip enable low
    S_GAP,     // Chip enable high between steps
    S_WAIT     // Device busy with a nonvolatile cycle
  } nvsc_state_t;

  typedef struct packed {
    nvsc_state_t       state;
    nvsc_cmd_t         cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [2:0]        step;      // Sequence step 0..5
    logic [1:0]        ph;        // Phase counter
    logic              rsp_v;
    logic [DATA_W-1:0] rdata;
    nvsc_pins_t        pins;
  } nvsc_st_t;

  nvsc_st_t st_reg;
  nvsc_st_t st_next;

  // Supply sense synchroniser
  logic pwr_s1_reg;
  logic pwr_s2_reg;
  logic pwr_prev_reg;

  // Timer hookup
  logic          tmr_load;
  logic [TW-1:0] tmr_count;
  logic          tmr_busy;
  logic          tmr_done;

  // Address for a given sequence step, upper bit held low
  function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] s, input nvsc_cmd_t c);
    logic [SEQ_W-1:0] a;
    a = SEQ_A1;
    case (s)
      3'h0: a = SEQ_A1;
      3'h1: a = SEQ_A2;
      3'h2: a = SEQ_A3;
      3'h3: a = SEQ_A4;
      3'h4: a = SEQ_A5;
      default: a = (c == NVSC_CMD_STORE) ? SEQ_ST : SEQ_RC;
    endcase
    return {1'b0, a};
  endfunction

  nvsc_timer #(
    .CNT_W     (TW)
  ) u_timer (
    .clk_in    (MCLK_IN),
    .arst_n_in (ARST_N_IN),
    .load_in   (tmr_load),
    .count_in  (tmr_count),
    .busy_out  (tmr_busy),
    .done_out  (tmr_done)
  );

  // Two-flop supply sense, then edge memory from the second flop
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      pwr_s1_reg   <= 1'b0;
      pwr_s2_reg   <= 1'b0;
      pwr_prev_reg <= 1'b0;
    end else begin
      pwr_s1_reg   <= PWR_OK_IN;
      pwr_s2_reg   <= pwr_s1_reg;
      pwr_prev_reg <= pwr_s2_reg;
    end
  end

  // Main sequencer
  always_comb begin
    st_next   = st_reg;
    tmr_load  = 1'b0;
    tmr_count = '0;
    st_next.rsp_v = 1'b0;
    case (st_reg.state)
      S_BOOT: begin
        // Write enable stays high so recall cannot corrupt the array
        st_next.pins.wr_en_n = 1'b1;
        if (pwr_s2_reg && !pwr_prev_reg) begin
          tmr_load  = 1'b1;
          tmr_count = TW'(PWRUP_CYC);
        end else if (pwr_s2_reg && !tmr_busy && !tmr_load) begin
          st_next.state = S_IDLE;
        end
      end
      S_IDLE: begin
        if (!pwr_s2_reg) begin
          st_next.state = S_BOOT;
        end else if (REQ_VALID_IN) begin
          st_next.cmd   = REQ_IN.cmd;
          st_next.wdata = REQ_IN.wdata;
          st_next.step  = 3'h0;
          st_next.ph    = '0;
          if (REQ_IN.cmd == NVSC_CMD_STORE || REQ_IN.cmd == NVSC_CMD_RECALL) begin
            st_next.addr = seq_addr(3'h0, REQ_IN.cmd);
          end else begin
            st_next.addr = REQ_IN.addr;
          end
          st_next.pins.byte_address_bus = st_next.addr;
          st_next.pins.byte_data_bus    = REQ_IN.wdata;
          st_next.pins.out_en_n         = 1'b1;
          st_next.state                 = S_SETUP;
        end
      end
      S_SETUP: begin
        // Address is stable before any strobe falls
        st_next.pins.chip_en_n = 1'b0;
        if (st_reg.cmd == NVSC_CMD_WRITE) begin
          st_next.pins.wr_en_n  = 1'b0;
          st_next.pins.out_en_n = 1'b1;
          st_next.pins.data_oe  = 1'b1;
        end else begin
          st_next.pins.wr_en_n  = 1'b1;
          st_next.pins.out_en_n = 1'b0;
        end
        st_next.ph    = '0;
        st_next.state = S_STROBE;
      end
      S_STROBE: begin
        // Address held through the whole strobe
        if (st_reg.ph == 2'(STROBE_CYC - 1)) begin
          st_next.pins.chip_en_n = 1'b1;
          st_next.pins.wr_en_n   = 1'b1;
          st_next.pins.out_en_n  = 1'b1;
          st_next.rdata          = MEM_DQ_IN;
          st_next.state          = S_GAP;
        end else begin
          st_next.ph = st_reg.ph + 2'h1;
        end
      end
      S_GAP: begin
        // Data released only after strobes are high again
        st_next.pins.data_oe = 1'b0;
        if (st_reg.cmd == NVSC_CMD_READ || st_reg.cmd == NVSC_CMD_WRITE) begin
          st_next.rsp_v = 1'b1;
          st_next.state = S_IDLE;
        end else if (st_reg.step == 3'(SEQ_STEPS - 1)) begin
          tmr_load      = 1'b1;
          tmr_count     = (st_reg.cmd == NVSC_CMD_STORE) ? TW'(STORE_CYC) : TW'(RECALL_CYC);
          st_next.state = S_WAIT;
        end else begin
          // Steps follow back to back, nothing else intervenes
          st_next.step                  = st_reg.step + 3'h1;
          st_next.addr                  = seq_addr(st_reg.step + 3'h1, st_reg.cmd);
          st_next.pins.byte_address_bus = st_next.addr;
          st_next.state                 = S_SETUP;
        end
      end
      S_WAIT: begin
        // Pins stay idle until the device finishes
        if (tmr_done) begin
          st_next.rsp_v = 1'b1;
          st_next.state = S_IDLE;
        end
      end
      default: st_next.state = S_BOOT;
    endcase
  end

  // State register, pins idle high at reset
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      st_reg                <= '0;
      st_reg.state          <= S_BOOT;
      st_reg.pins.chip_en_n <= 1'b1;
      st_reg.pins.out_en_n  <= 1'b1;
      st_reg.pins.wr_en_n   <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign REQ_READY_OUT     = (st_reg.state == S_IDLE) && pwr_s2_reg;
  assign RSP_VALID_OUT     = st_reg.rsp_v;
  assign RSP_RDATA_OUT     = st_reg.rdata;
  assign STORE_INHIBIT_OUT = !pwr_s2_reg;
  assign MEM_PINS_OUT      = st_reg.pins;

  AST_WR_OE_HIGH: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
    !st_reg.pins.wr_en_n |-> st_reg.pins.out_en_n) else $error("output enable low during write");
  AST_WR_NEEDS_CE: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
    !st_reg.pins.wr_en_n |-> !st_reg.pins.chip_en_n) else $error("write strobe without chip enable");
  AST_ADDR_STABLE: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
    (!st_reg.pins.chip_en_n && !$past(st_reg.pins.chip_en_n)) |-> $stable(st_reg.pins.byte_address_bus))
    else $error("address moved during strobe");
  AST_CE_TOGGLE: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
    $fell(st_reg.pins.chip_en_n) |-> ##2 st_reg.pins.chip_en_n) else $error("strobe length wrong");
  AST_SEQ_READ: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
    (st_reg.cmd inside {NVSC_CMD_STORE, NVSC_CMD_RECALL} && !st_reg.pins.chip_en_n) |-> st_reg.pins.wr_en_n)
    else $error("sequence step is not a read");
  AST_SEQ_MSB: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
    (st_reg.cmd inside {NVSC_CMD_STORE, NVSC_CMD_RECALL} && !st_reg.pins.chip_en_n)
    |-> !st_reg.pins.byte_address_bus[ADDR_W-1]) else $error("sequence top bit set");
  AST_WAIT_IDLE: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
    st_reg.state == S_WAIT |-> st_reg.pins.chip_en_n && st_reg.pins.wr_en_n) else $error("access while busy");
  AST_INHIBIT: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
    !pwr_s2_reg |-> !REQ_READY_OUT && STORE_INHIBIT_OUT) else $error("request taken at low supply");
  // An idle host that loses supply must go back and wait for the recall
  AST_LOW_TO_BOOT: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
    (st_reg.state == S_IDLE && !pwr_s2_reg) |=> st_reg.state == S_BOOT) else $error("no return to boot at low supply");
  AST_BOOT_WE: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
    st_reg.state == S_BOOT |-> st_reg.pins.wr_en_n) else $error("write enable low during recall");

endmodule

// ===== rtl/nvsc_pkg.sv
package nvsc_pkg;

  // Bus geometry
  localparam int ADDR_W    = 15;
  localparam int DATA_W    = 8;
  localparam int SEQ_W     = 14;
  localparam int SEQ_STEPS = 6;

  // Clock rate and timing figures
  localparam int CLK_HZ            = 20_000_000;
  localparam int CLK_NS            = 50;
  localparam int STORE_TIME_MS     = 10;
  localparam int RECALL_TIME_US    = 20;
  localparam int PU_RECALL_TIME_US = 650;
  localparam int SOFT_STORE_CYC    = STORE_TIME_MS * (CLK_HZ / 1000);
  localparam int SOFT_RECALL_CYC   = RECALL_TIME_US * (CLK_HZ / 1_000_000);
  localparam int PU_RECALL_CYC     = PU_RECALL_TIME_US * (CLK_HZ / 1_000_000);

  // Bus phase lengths in clocks (address setup, strobe)
  localparam int SETUP_CYC  = 1;
  localparam int STROBE_CYC = 2;

  // Sequence addresses
  localparam logic [SEQ_W-1:0] SEQ_A1 = 14'h0E38;
  localparam logic [SEQ_W-1:0] SEQ_A2 = 14'h31C7;
  localparam logic [SEQ_W-1:0] SEQ_A3 = 14'h03E0;
  localparam logic [SEQ_W-1:0] SEQ_A4 = 14'h3C1F;
  localparam logic [SEQ_W-1:0] SEQ_A5 = 14'h303F;
  localparam logic [SEQ_W-1:0] SEQ_ST = 14'h0FC0;
  localparam logic [SEQ_W-1:0] SEQ_RC = 14'h0C63;

  // User command codes
  typedef enum logic [1:0] {
    NVSC_CMD_READ,
    NVSC_CMD_WRITE,
    NVSC_CMD_STORE,
    NVSC_CMD_RECALL
  } nvsc_cmd_t;

  // User request bundle
  typedef struct packed {
    nvsc_cmd_t         cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } nvsc_req_t;

  // Pins toward the memory device
  typedef struct packed {
    logic [ADDR_W-1:0] byte_address_bus;
    logic [DATA_W-1:0] byte_data_bus;
    logic              data_oe;
    logic              chip_en_n;
    logic              out_en_n;
    logic              wr_en_n;
  } nvsc_pins_t;

endpackage

// ===== rtl/nvsc_timer.sv
`timescale 1ns/1ps
// Busy-wait counter: loads a cycle count and pulses done when it runs out
module nvsc_timer #(
  parameter int CNT_W = 24
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             arst_n_in,
  // Control
  input  wire logic             load_in,
  input  wire logic [CNT_W-1:0] count_in,
  // Status
  output logic                  busy_out,
  output logic                  done_out
);
  import nvsc_pkg::*;

  initial begin
    if (CNT_W < 2) $error("CNT_W too small");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;   // Remaining cycles
    logic             busy;  // Counting
    logic             done;  // One-cycle end pulse
  } nvsc_tmr_t;

  nvsc_tmr_t st_reg;
  nvsc_tmr_t st_next;

  // Count down; a load restarts the count even while busy
  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    if (load_in) begin
      st_next.cnt  = count_in;
      st_next.busy = 1'b1;
    end else if (st_reg.busy) begin
      if (st_reg.cnt <= CNT_W'(1)) begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
        st_next.cnt  = '0;
      end else begin
        st_next.cnt = st_reg.cnt - CNT_W'(1);
      end
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy_out = st_reg.busy;
  assign done_out = st_reg.done;

endmodule

// ===== verif/nvsc_dev_model.sv
`timescale 1ns/1ps
// Behavioural memory device at the far side of the host; busy times in ns
module nvsc_dev_model #(
  parameter int BUSY_NS  = 200,  // Store and recall busy time, kept below the host wait
  parameter int PWRUP_NS = 200   // Power-up recall busy time
) (
  // Pins from the host
  input  wire nvsc_pkg::nvsc_pins_t            pins_in,
  input  wire logic                            pwr_ok_in,
  // Data toward the host
  output logic [nvsc_pkg::DATA_W-1:0]          dq_out,
  output logic                                 dq_oe_out
);
  import nvsc_pkg::*;

  logic [DATA_W-1:0] sram_mem [0:32767];  // Volatile array, one byte per location
  logic [DATA_W-1:0] nv_mem   [0:32767];  // Shadow copy
  logic [SEQ_W-1:0]  seq_tab  [0:4];      // First five sequence addresses
  logic              busy_reg;            // Nonvolatile cycle in progress
  logic              dirty_reg;           // Written since last store or recall
  logic              pend_reg;            // Recall waiting for supply
  int                step_reg;            // Sequence steps matched so far
  logic [DATA_W-1:0] last_reg;            // Last value driven, inverted when released
  logic              wr_on_reg;           // Write strobe pair seen low, so its end is a real write
  wire logic [SEQ_W-1:0] seq_a  = pins_in.byte_address_bus[SEQ_W-1:0];
  wire logic             wr_act = !pins_in.chip_en_n && !pins_in.wr_en_n && !busy_reg && pwr_ok_in;

  // Nonvolatile side starts with a known pattern so recall is visible
  initial begin
    busy_reg  = 1'b0;
    dirty_reg = 1'b0;
    pend_reg  = 1'b1;
    step_reg  = 0;
    last_reg  = 8'h00;
    wr_on_reg = 1'b0;
    seq_tab   = '{SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4, SEQ_A5};
    for (int i = 0; i < 32768; i++) nv_mem[i] = 8'hA5;
  end

  // Read path follows the address; released bus shows the inverse, never a friendly value
  assign dq_oe_out = !pins_in.chip_en_n && !pins_in.out_en_n && pins_in.wr_en_n && !busy_reg && pwr_ok_in;
  always @* if (dq_oe_out) last_reg = sram_mem[pins_in.byte_address_bus];
  assign dq_out = dq_oe_out ? sram_mem[pins_in.byte_address_bus] : ~last_reg;

  // Write data is taken when the write strobe pair ends; the unknown-to-low step at time zero is no write
  always @(posedge wr_act) wr_on_reg = 1'b1;
  always @(negedge wr_act) begin
    if (wr_on_reg === 1'b1) begin
      sram_mem[pins_in.byte_address_bus] = pins_in.byte_data_bus;
      dirty_reg = 1'b1;
      step_reg  = 0;
    end
    wr_on_reg = 1'b0;
  end

  // Store copies the array over the shadow; recall copies the shadow back over the array
  task automatic nv_op(input bit is_store);
    busy_reg = 1'b1;
    step_reg = 0;
    #(BUSY_NS);
    for (int i = 0; i < 32768; i++) begin
      if (is_store) nv_mem[i] = sram_mem[i];
      else sram_mem[i] = nv_mem[i];
    end
    dirty_reg = 1'b0;
    busy_reg  = 1'b0;
  endtask

  // Sequence is clocked by chip enable on reads only; output enable plays no part
  always @(negedge pins_in.chip_en_n) begin
    if (!busy_reg && pwr_ok_in && pins_in.wr_en_n) begin
      if (step_reg == 5 && seq_a == SEQ_ST) nv_op(1'b1);
      else if (step_reg == 5 && seq_a == SEQ_RC) nv_op(1'b0);
      else if (step_reg < 5 && seq_a == seq_tab[step_reg]) step_reg++;
      else step_reg = (seq_a == SEQ_A1) ? 1 : 0;
    end
  end

  // Supply loss: store only if dirty, and latch a recall for the return
  always @(negedge pwr_ok_in) begin
    if (dirty_reg) for (int i = 0; i < 32768; i++) nv_mem[i] = sram_mem[i];
    dirty_reg = 1'b0;
    pend_reg  = 1'b1;
    step_reg  = 0;
  end

  // Supply return runs the latched recall
  always @(posedge pwr_ok_in) begin
    if (pend_reg) begin
      busy_reg = 1'b1;
      #(PWRUP_NS);
      for (int i = 0; i < 32768; i++) sram_mem[i] = nv_mem[i];
      dirty_reg = 1'b0;
      pend_reg = 1'b0;
      busy_reg = 1'b0;
    end
  end
endmodule

// ===== verif/nvsc_host_bench.sv
`timescale 1ns/1ps
// Compare two values and count the outcome
`define NVSC_CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
  $display("MISMATCH %s expected %h seen %h", what, exp, got); end end
module nvsc_host_bench;
  import nvsc_pkg::*;

  logic                 mclk;             // 20 MHz clock
  logic                 arst_n;           // Reset, active low
  logic                 pwr_ok;           // Supply sense
  logic                 req_valid;        // Request strobe
  nvsc_req_t            req;              // Request bundle
  logic                 req_ready;        // Host ready
  logic                 rsp_valid;        // Completion pulse
  logic [DATA_W-1:0]    rsp_rdata;        // Read data
  logic                 inhibit;          // Store inhibit flag
  nvsc_pins_t           pins;             // Host pins
  logic [DATA_W-1:0]    dev_dq;           // Device data
  logic                 dev_oe;           // Device drives data
  logic [DATA_W-1:0]    dq_wire;          // Resolved data bus
  int                   n_fail;           // Mismatches
  int                   samples_checked;  // Comparisons
  int                   cyc;              // Cycle count for the hang guard
  logic [DATA_W-1:0]    rd;               // Last read result

  // Short busy counts keep the run brief
  nvsc_host #(.STORE_CYC(5), .RECALL_CYC(5), .PWRUP_CYC(5)) dut (
    .MCLK_IN(mclk), .ARST_N_IN(arst_n), .REQ_VALID_IN(req_valid), .REQ_IN(req),
    .REQ_READY_OUT(req_ready), .RSP_VALID_OUT(rsp_valid), .RSP_RDATA_OUT(rsp_rdata),
    .STORE_INHIBIT_OUT(inhibit), .PWR_OK_IN(pwr_ok), .MEM_PINS_OUT(pins), .MEM_DQ_IN(dq_wire));

  nvsc_dev_model #(.BUSY_NS(200), .PWRUP_NS(200)) mem (
    .pins_in(pins), .pwr_ok_in(pwr_ok), .dq_out(dev_dq), .dq_oe_out(dev_oe));

  // Whoever enables drives the shared data lines
  assign dq_wire = pins.data_oe ? pins.byte_data_bus : dev_dq;

  // Clock generator
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Watch the pins for output enable in writes and bus fights, away from the edge that moves them
  always @(negedge mclk) begin
    if (arst_n && !pins.wr_en_n) `NVSC_CHK("oe_in_write", 1'b1, pins.out_en_n)
    if (arst_n) `NVSC_CHK("contention", 1'b0, pins.data_oe & dev_oe)
  end

  // Hang guard: far above the few hundred cycles the tests need
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic conclude();
    if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // One request: wait for ready, hold valid over the taking edge, wait for the pulse
  task automatic xfer(input nvsc_cmd_t cmd, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(negedge mclk);
    while (req_ready !== 1'b1 && n < 400) begin
      @(negedge mclk);
      n++;
    end
    req       = '{cmd, a, d};
    req_valid = 1'b1;
    @(negedge mclk);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 400) begin
      @(negedge mclk);
      n++;
    end
    `NVSC_CHK("rsp_valid", 1'b1, rsp_valid)
    rd = rsp_rdata;
  endtask

  // Boot: flags in reset, then ready once supply is seen
  task automatic t_boot();
    `NVSC_CHK("inhibit_rst", 1'b1, inhibit)
    `NVSC_CHK("ready_rst", 1'b0, req_ready)
    @(negedge mclk);
    arst_n = 1'b1;
    pwr_ok = 1'b1;
    xfer(NVSC_CMD_READ, 15'h1234, 8'h00);
    `NVSC_CHK("pwrup_recall", 8'hA5, rd)
    `NVSC_CHK("inhibit_ok", 1'b0, inhibit)
  endtask

  // Back-to-back writes at both ends of the range, then read back
  task automatic t_rw();
    xfer(NVSC_CMD_WRITE, 15'h7FFF, 8'h3C);
    xfer(NVSC_CMD_WRITE, 15'h0000, 8'hC3);
    xfer(NVSC_CMD_WRITE, 15'h4E38, 8'h77);
    xfer(NVSC_CMD_READ, 15'h7FFF, 8'h00);
    `NVSC_CHK("rd_top", 8'h3C, rd)
    xfer(NVSC_CMD_READ, 15'h0000, 8'h00);
    `NVSC_CHK("rd_zero", 8'hC3, rd)
    xfer(NVSC_CMD_READ, 15'h4E38, 8'h00);
    `NVSC_CHK("rd_seqlike", 8'h77, rd)
  endtask

  // Store, overwrite, recall: the stored byte must come back
  task automatic t_store_recall();
    xfer(NVSC_CMD_WRITE, 15'h0100, 8'h11);
    xfer(NVSC_CMD_STORE, 15'h0000, 8'h00);
    xfer(NVSC_CMD_WRITE, 15'h0100, 8'h22);
    xfer(NVSC_CMD_READ, 15'h0100, 8'h00);
    `NVSC_CHK("rd_after_store", 8'h22, rd)
    xfer(NVSC_CMD_RECALL, 15'h0000, 8'h00);
    xfer(NVSC_CMD_READ, 15'h0100, 8'h00);
    `NVSC_CHK("rd_recalled", 8'h11, rd)
    xfer(NVSC_CMD_READ, 15'h7FFF, 8'h00);
    `NVSC_CHK("rd_recalled_top", 8'h3C, rd)
  endtask

  // Supply dip after a write: inhibit while low, data kept through the dip
  task automatic t_power();
    xfer(NVSC_CMD_WRITE, 15'h0200, 8'h5A);
    @(negedge mclk);
    pwr_ok = 1'b0;
    repeat (6) @(negedge mclk);
    `NVSC_CHK("inhibit_low", 1'b1, inhibit)
    `NVSC_CHK("ready_low", 1'b0, req_ready)
    pwr_ok = 1'b1;
    xfer(NVSC_CMD_READ, 15'h0200, 8'h00);
    `NVSC_CHK("rd_autostore", 8'h5A, rd)
  endtask

  // Main sequence: inputs defined at time zero, reset held for 8 cycles
  initial begin
    arst_n          = 1'b0;
    pwr_ok          = 1'b0;
    req_valid       = 1'b0;
    req             = '0;
    n_fail          = 0;
    samples_checked = 0;
    cyc             = 0;
    repeat (8) @(posedge mclk);
    t_boot();
    t_rw();
    t_store_recall();
    t_power();
    conclude();
  end
endmodule
